/* srm_regs.svh */
// Register map, field positions, reset values and timing counts
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

// Byte addresses
`define SRM_CFG_ADDR      8'h00
`define SRM_CMD_ADDR      8'h04
`define SRM_STAT_ADDR     8'h08
`define SRM_ROUTE_ADDR    8'h0C

// Field positions
`define SRM_CMD_SRC_LSB   0
`define SRM_CMD_DST_LSB   4
`define SRM_CMD_OP_LSB    8
`define SRM_ST_IN_LSB     8
`define SRM_ST_OUT_LSB    16
`define SRM_ST_FF_LSB     24

// Reset value of the configuration register
`define SRM_CFG_RST       7'h00

// Line count limits for variant one
`define SRM_HS_IN_MAX     4
`define SRM_HS_OUT_MAX    4
`define SRM_LS_IN_MAX     2
`define SRM_LS_OUT_MAX    3

// Timing: least pulse length on a variant one line
`define SRM_CLK_NS        4
`define SRM_MIN_PULSE_NS  100000
`define SRM_MIN_PULSE_CYC ((`SRM_MIN_PULSE_NS + `SRM_CLK_NS - 1) / `SRM_CLK_NS)

// Bus responses
`define SRM_RESP_OKAY     2'h0
`define SRM_RESP_SLVERR   2'h2

`endif

/* srm_pkg.sv */
// Types shared by the routing matrix
package srm_pkg;

  // Terminal codes, in order 0..15
  typedef enum logic [3:0] {
    T_LINE0, T_LINE1, T_LINE2, T_LINE3, T_LINE4, T_LINE5, T_LINE6,
    T_CLOCK_LINE, T_STAR, T_CLK10, T_TB_EXPORT, T_RESYNC,
    T_RX_EVENT, T_XCVR_EVENT, T_START, T_MTB
  } srm_term_t;

  // Hardware variant
  typedef enum logic [1:0] {SER_1, SER_2, SER_PLAIN, SER_3} srm_series_t;

  // Form factor code
  typedef enum logic [2:0] {
    FF_BOARD, FF_BACKPLANE, FF_CARD, FF_LEGACY, FF_DONGLE
  } srm_ff_t;

  // Command operations
  typedef enum logic [1:0] {
    OP_CONNECT, OP_DISCONNECT, OP_CLOSE_LAST, OP_NONE
  } srm_op_t;

  // Configuration register
  typedef struct packed {
    logic        ls_port;
    logic        port2;
    srm_ff_t     ff;
    srm_series_t series;
  } srm_cfg_t;

  // Whole state of the matrix
  typedef struct packed {
    srm_cfg_t         cfg;
    logic [15:0]      rt_valid;
    logic [15:0][3:0] rt_src;
    logic             err;
    logic [9:0]       sync1;
    logic [9:0]       sync2;
    logic [7:0]       line_val;
    logic [7:0][15:0] fcnt;
    logic [7:0]       line_out;
    logic [7:0]       line_oe_n;
    logic [2:0]       prev;
    logic             armed;
    logic             start_trigger_connector_terminal;
    logic             resync_pulse;
    logic             mtb_tick;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } srm_state_t;

endpackage

/* srm_sync_route_matrix.sv */
// Sync-bus routing matrix with an AXI4-Lite register slave
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "srm_regs.svh"

module srm_sync_route_matrix
  import srm_pkg::*;
#(
  parameter int MIN_PULSE_CYC = `SRM_MIN_PULSE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  sync_bus_line_in,
  output logic [7:0]       sync_bus_line_out,
  output logic [7:0]       sync_bus_line_oe_n,
  input  wire logic        backplane_star_trigger,
  input  wire logic        backplane_10mhz_clock,
  input  wire logic        tb_export,
  input  wire logic        resync_local,
  input  wire logic        rx_event,
  input  wire logic        xcvr_event,
  input  wire logic        start_event,
  input  wire logic        comm_start,
  output logic             start_trigger,
  output logic             resync_pulse,
  output logic [1:0]       mtb_source,
  output logic             mtb_tick,
  output logic             export_1mhz
);

  srm_state_t s;             // Registered state
  srm_state_t next_s;        // Next state
  logic [15:0] tv;           // Level of every source terminal
  logic [7:0]  in_mask;      // Lines used as inputs
  logic        wr_go;        // Write address and data taken
  logic        ar_go;        // Read address taken
  logic        cmd_go;       // Command register written
  srm_op_t     cmd_op;       // Command operation
  srm_term_t   cmd_src;      // Command source
  srm_term_t   cmd_dst;      // Command destination
  logic        start_lvl;    // Routed start source level
  logic        resync_lvl;   // Routed resync source level
  logic        mtb_lvl;      // Routed timebase source level

  localparam srm_state_t RST = '{cfg: srm_cfg_t'(`SRM_CFG_RST),
                                 line_oe_n: 8'hFF, default: '0};

  // Count of set bits in a line mask
  function automatic int unsigned popcnt(input logic [7:0] m);
    int unsigned c;
    c = 0;
    for (int i = 0; i < 8; i++) begin
      c = c + int'(m[i]);
    end
    return c;
  endfunction

  // Lines referenced as sources by valid routes
  function automatic logic [7:0] inputs_of(input logic [15:0] v,
                                           input logic [15:0][3:0] r);
    logic [7:0] m;
    m = 8'h00;
    for (int d = 0; d < 16; d++) begin
      if (v[d] && !r[d][3]) begin
        m[r[d][2:0]] = 1'b1;
      end
    end
    return m;
  endfunction

  // Allowed source/destination pairs per variant and form factor
  function automatic logic pair_ok(input srm_cfg_t c, input srm_term_t sr,
                                   input srm_term_t ds);
    logic ok;
    logic ls;
    logic ld;
    logic base;
    ls = (sr <= T_LINE6);
    ld = (ds <= T_LINE6);
    base = (ls && (ds == T_RESYNC || ds == T_START)) ||
           (sr == T_RESYNC && (ld || ds == T_START)) ||
           (sr == T_START && ld);
    ok = 1'b0;
    case (c.series)
      SER_1: begin
        ok = base;
        if (c.ff == FF_BACKPLANE && (sr == T_LINE6 || ds == T_LINE6)) begin
          ok = 1'b0;
        end
      end
      SER_2: begin
        ok = base ||
             (sr == T_CLOCK_LINE && ds == T_MTB) ||
             (sr == T_CLK10 && ds == T_MTB) ||
             (sr == T_STAR && ds == T_START) ||
             (sr == T_TB_EXPORT && ds == T_CLOCK_LINE) ||
             (sr == T_RX_EVENT && (ld || ds == T_START));
        if (sr == T_XCVR_EVENT && ld && (ds[0] == c.port2)) begin
          ok = 1'b1;
        end
        if (c.ff == FF_BOARD && (sr == T_STAR || sr == T_CLK10)) begin
          ok = 1'b0;
        end
        if (c.ff == FF_CARD) begin
          if (sr == T_TB_EXPORT || sr == T_STAR || sr == T_CLK10) begin
            ok = 1'b0;
          end
          if ((sr >= T_LINE4 && sr <= T_LINE6) ||
              (ds >= T_LINE4 && ds <= T_LINE6)) begin
            ok = 1'b0;
          end
        end
      end
      SER_3: begin
        ok = (sr == T_LINE0 && ds == T_START) ||
             (sr == T_CLOCK_LINE && ds == T_MTB) ||
             (sr == T_TB_EXPORT && ds == T_CLOCK_LINE) ||
             (sr == T_START && ds == T_LINE0);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // Source terminal levels; lines come filtered or synchronised
  assign tv = {1'b0, start_event, xcvr_event, rx_event, resync_local,
               tb_export, s.sync2[9], s.sync2[8], s.line_val};
  assign in_mask    = inputs_of(s.rt_valid, s.rt_src);
  assign start_lvl  = tv[s.rt_src[T_START]];
  assign resync_lvl = tv[s.rt_src[T_RESYNC]];
  assign mtb_lvl    = tv[s.rt_src[T_MTB]];

  // Bus handshakes: both write channels are taken together
  assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign ar_go   = s_axi_arvalid && !s.rvalid;
  assign cmd_go  = wr_go && s_axi_awaddr == `SRM_CMD_ADDR &&
                   s_axi_wstrb[1:0] == 2'h3;
  assign cmd_op  = srm_op_t'(s_axi_wdata[`SRM_CMD_OP_LSB +: 2]);
  assign cmd_src = srm_term_t'(s_axi_wdata[`SRM_CMD_SRC_LSB +: 4]);
  assign cmd_dst = srm_term_t'(s_axi_wdata[`SRM_CMD_DST_LSB +: 4]);

  // Next-state logic
  always_comb begin
    logic [7:0]  new_in;
    logic [7:0]  new_out;
    int unsigned lim_in;
    int unsigned lim_out;
    logic        ok;
    new_in  = in_mask;
    new_out = s.rt_valid[7:0];
    lim_in  = 8;
    lim_out = 8;
    ok      = 1'b0;
    next_s  = s;

    // Two-stage synchronisers for pins
    next_s.sync1 = {backplane_10mhz_clock, backplane_star_trigger,
                    sync_bus_line_in};
    next_s.sync2 = s.sync1;

    // Variant one keeps a level only once it has lasted long enough
    for (int i = 0; i < 8; i++) begin
      if (s.cfg.series != SER_1) begin
        next_s.line_val[i] = s.sync2[i];
        next_s.fcnt[i] = 16'h0000;
      end else if (s.sync2[i] == s.line_val[i]) begin
        next_s.fcnt[i] = 16'h0000;
      end else if (s.fcnt[i] >= 16'(MIN_PULSE_CYC - 1)) begin
        next_s.line_val[i] = s.sync2[i];
        next_s.fcnt[i] = 16'h0000;
      end else begin
        next_s.fcnt[i] = s.fcnt[i] + 16'h0001;
      end
    end

    // Line drivers; unrouted lines are released
    for (int i = 0; i < 8; i++) begin
      next_s.line_out[i]  = s.rt_valid[i] && tv[s.rt_src[i]];
      next_s.line_oe_n[i] = !s.rt_valid[i];
    end

    // Start trigger: first rising edge once armed, else at start
    next_s.prev = {mtb_lvl, resync_lvl, start_lvl};
    next_s.start_trigger_connector_terminal = 1'b0;
    if (s.armed && start_lvl && !s.prev[0]) begin
      next_s.start_trigger_connector_terminal = 1'b1;
      next_s.armed = 1'b0;
    end
    if (comm_start) begin
      if (s.rt_valid[T_START]) begin
        next_s.armed = 1'b1;
      end else begin
        next_s.start_trigger_connector_terminal = 1'b1;
      end
    end

    // Resync and imported timebase edges
    next_s.resync_pulse = s.rt_valid[T_RESYNC] && resync_lvl &&
                          !s.prev[1];
    next_s.mtb_tick = s.rt_valid[T_MTB] && mtb_lvl && !s.prev[2];

    // Write channel
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = `SRM_RESP_OKAY;
      if (s_axi_awaddr == `SRM_CFG_ADDR) begin
        if (s_axi_wstrb[0]) begin
          // New variant invalidates every route
          next_s.cfg = srm_cfg_t'(s_axi_wdata[6:0]);
          next_s.rt_valid = 16'h0000;
          next_s.armed = 1'b0;
        end
      end else if (s_axi_awaddr == `SRM_CMD_ADDR) begin
        if (cmd_go) begin
          case (cmd_op)
            OP_CONNECT: begin
              if (!cmd_src[3]) begin
                new_in[cmd_src[2:0]] = 1'b1;
              end
              if (!cmd_dst[3]) begin
                new_out[cmd_dst[2:0]] = 1'b1;
              end
              if (s.cfg.series == SER_1) begin
                lim_in  = s.cfg.ls_port ? `SRM_LS_IN_MAX : `SRM_HS_IN_MAX;
                lim_out = s.cfg.ls_port ? `SRM_LS_OUT_MAX : `SRM_HS_OUT_MAX;
              end
              ok = pair_ok(s.cfg, cmd_src, cmd_dst) &&
                   !s.rt_valid[cmd_dst] &&
                   (new_in & new_out) == 8'h00 &&
                   popcnt(new_in) <= lim_in &&
                   popcnt(new_out) <= lim_out;
              if (ok) begin
                next_s.rt_valid[cmd_dst] = 1'b1;
                next_s.rt_src[cmd_dst] = cmd_src;
              end
              next_s.err = !ok;
            end
            OP_DISCONNECT: begin
              ok = s.rt_valid[cmd_dst] && s.rt_src[cmd_dst] == cmd_src;
              if (ok) begin
                next_s.rt_valid[cmd_dst] = 1'b0;
                if (cmd_dst == T_START) begin
                  next_s.armed = 1'b0;
                end
              end
              next_s.err = !ok;
            end
            OP_CLOSE_LAST: begin
              next_s.rt_valid = 16'h0000;
              next_s.armed = 1'b0;
              next_s.err = 1'b0;
            end
            default: begin
              next_s.err = 1'b1;
            end
          endcase
        end else begin
          next_s.bresp = `SRM_RESP_SLVERR;
        end
      end else begin
        next_s.bresp = `SRM_RESP_SLVERR;
      end
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `SRM_RESP_OKAY;
      next_s.rdata  = 32'h00000000;
      if (s_axi_araddr == `SRM_CFG_ADDR) begin
        next_s.rdata[6:0] = s.cfg;
      end else if (s_axi_araddr == `SRM_CMD_ADDR) begin
        next_s.rdata = 32'h00000000;
      end else if (s_axi_araddr == `SRM_STAT_ADDR) begin
        next_s.rdata[0] = s.err;
        next_s.rdata[`SRM_ST_IN_LSB +: 8]  = in_mask;
        next_s.rdata[`SRM_ST_OUT_LSB +: 8] = s.rt_valid[7:0];
        next_s.rdata[`SRM_ST_FF_LSB +: 3]  = s.cfg.ff;
      end else if (s_axi_araddr == `SRM_ROUTE_ADDR) begin
        next_s.rdata[15:0] = s.rt_valid;
      end else begin
        next_s.rresp = `SRM_RESP_SLVERR;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign s_axi_awready      = wr_go;
  assign s_axi_wready       = wr_go;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = !s.rvalid;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rdata        = s.rdata;
  assign sync_bus_line_out  = s.line_out;
  assign sync_bus_line_oe_n = s.line_oe_n;
  assign start_trigger      = s.start_trigger_connector_terminal;
  assign resync_pulse       = s.resync_pulse;
  assign mtb_tick           = s.mtb_tick;
  assign mtb_source         = !s.rt_valid[T_MTB] ? 2'h0 :
                              (s.rt_src[T_MTB] == T_CLK10) ? 2'h2 : 2'h1;
  assign export_1mhz        = (s.cfg.series == SER_3);

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_connect;
    cmd_go && cmd_op == OP_CONNECT;
  endsequence

  sequence s_start_edge;
    s.armed && start_lvl && !s.prev[0];
  endsequence

  a_line6_blocked: assert property (
    s_connect and (s.cfg.series == SER_1 && s.cfg.ff == FF_BACKPLANE &&
    (cmd_src == T_LINE6 || cmd_dst == T_LINE6)) |=> s.err)
    else $error("line six routed on backplane variant one");

  a_reject_keeps: assert property (
    cmd_go ##1 s.err |-> s.rt_valid == $past(s.rt_valid) &&
    s.rt_src == $past(s.rt_src))
    else $error("rejected request changed routes");

  a_close_drops: assert property (
    cmd_go && cmd_op == OP_CLOSE_LAST |=> s.rt_valid == 16'h0000)
    else $error("routes survive close");

  a_hs_limits: assert property (
    s.cfg.series == SER_1 && !s.cfg.ls_port |->
    popcnt(in_mask) <= 4 && popcnt(s.rt_valid[7:0]) <= 4)
    else $error("high-speed line limit exceeded");

  a_ls_limits: assert property (
    s.cfg.series == SER_1 && s.cfg.ls_port |->
    popcnt(in_mask) <= 2 && popcnt(s.rt_valid[7:0]) <= 3)
    else $error("low-speed line limit exceeded");

  a_card_lines: assert property (
    s.cfg.series == SER_2 && s.cfg.ff == FF_CARD |->
    ((in_mask | s.rt_valid[7:0]) & 8'h70) == 8'h00)
    else $error("absent line used on card variant");

  a_v3_lines: assert property (
    s.cfg.series == SER_3 |-> ((in_mask | s.rt_valid[7:0]) & 8'h7E) == 8'h00)
    else $error("unsupported line used on variant three");

  a_line_dir: assert property (
    (in_mask & s.rt_valid[7:0]) == 8'h00 &&
    (~$past(s.rt_valid[7:0]) & ~s.line_oe_n) == 8'h00)
    else $error("line used both ways or driven unrouted");

  a_start_first: assert property (
    s_start_edge |=> start_trigger ##1 !s.armed)
    else $error("start trigger missed first edge");

  a_resync_edge: assert property (
    s.rt_valid[T_RESYNC] && resync_lvl && !s.prev[1] |=> resync_pulse)
    else $error("resync edge not followed by pulse");

  a_pulse_filter: assert property (
    $past(s.cfg.series) == SER_1 && s.cfg.series == SER_1 &&
    $changed(s.line_val[0]) |-> $past(s.fcnt[0]) == 16'(MIN_PULSE_CYC - 1))
    else $error("short line pulse accepted");

endmodule

/* srm_sync_bus_partner.sv */
// Far-side sync-bus boards: line drivers and a free-phase link clock
`timescale 1ns/1ps

module srm_sync_bus_partner (
  input  wire logic [7:0] line_out,
  input  wire logic [7:0] line_oe_n,
  input  wire logic       mclk,
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_val,
  input  wire logic [7:0] clk_mask,
  input  wire logic       clk_run,
  output logic      [7:0] line_in
);
  logic [7:0] patt = 8'h00;  // Level shown on a line nobody drives
  logic       link_clk;      // Link clock, low outside frames

  // A line nobody drives flips each cycle so no stale level survives
  always @(posedge mclk) begin
    patt <= ~line_in;
  end

  // Link clock of 32 ns, phase unrelated to the bench clock
  initial begin
    link_clk = 1'b0;
    forever begin
      wait (clk_run === 1'b1);
      #7.3;
      while (clk_run === 1'b1) begin
        link_clk = 1'b1;
        #16;
        link_clk = 1'b0;
        #16;
      end
    end
  end

  // Wire level: device first, then the clock, then the far boards
  assign line_in = (~line_oe_n & line_out)
                 | (line_oe_n & clk_mask & {8{link_clk}})
                 | (line_oe_n & ~clk_mask & drive_en & drive_val)
                 | (line_oe_n & ~clk_mask & ~drive_en & patt);
endmodule

/* tb_srm_sync_route_matrix.sv */
// Self-checking bench for the sync-bus routing matrix
`timescale 1ns/1ps
`include "srm_regs.svh"

module tb_srm_sync_route_matrix
  import srm_pkg::*;
;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [11:0] ev = 12'h000;       // Random event, trigger, prot inputs
  logic [11:0] ev_d = 12'h000;     // Event inputs one cycle late
  logic        bp_clk10 = 1'b0;    // Backplane 10 MHz clock level
  logic        comm_start = 1'b0;
  logic [7:0]  drive_en = 8'h00;   // Far boards driving a line
  logic [7:0]  drive_val = 8'h00;
  logic [7:0]  clk_mask = 8'h00;   // Lines that carry the link clock
  logic        clk_run = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, mtb_source;
  logic [31:0] rdata;
  logic [7:0]  line_in, line_out, line_oe_n;
  logic        start_trigger, resync_pulse, mtb_tick, export_1mhz;
  logic [65:0] rq[$];              // Notes: resp, mask, data
  logic [65:0] rn;
  logic [1:0]  bq[$];
  logic        st_q[$], rs_q[$], mt_q[$];
  logic [6:0]  cur_cfg = 7'h7F;
  int          error_cnt = 0;
  int          check_count = 0;

  srm_sync_route_matrix #(.MIN_PULSE_CYC(8)) dut (
    .mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(ev[8:6]),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(ev[11:9]), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(s_axi_rready), .sync_bus_line_in(line_in),
    .sync_bus_line_out(line_out), .sync_bus_line_oe_n(line_oe_n),
    .backplane_star_trigger(ev[5]), .backplane_10mhz_clock(bp_clk10),
    .tb_export(ev[0]), .resync_local(ev[1]), .rx_event(ev[2]),
    .xcvr_event(ev[3]), .start_event(ev[4]),
    .comm_start(comm_start), .start_trigger(start_trigger),
    .resync_pulse(resync_pulse), .mtb_source(mtb_source),
    .mtb_tick(mtb_tick), .export_1mhz(export_1mhz)
  );

  srm_sync_bus_partner far (
    .line_out(line_out), .line_oe_n(line_oe_n), .mclk(mclk),
    .drive_en(drive_en), .drive_val(drive_val), .clk_mask(clk_mask),
    .clk_run(clk_run), .line_in(line_in)
  );

  // Bench clock, 4 ns
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Event sources change at random every cycle
  always @(posedge mclk) begin
    ev <= 12'($urandom);
    ev_d <= ev;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    @(posedge mclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (!(awready === 1'b1 && wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // Read: the expected word, its mask and response go on the queue
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] r);
    @(posedge mclk);
    rq.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // One routing command, then the error flag it must leave behind
  task automatic do_cmd(input logic [6:0] c, input srm_term_t s,
                        input srm_term_t d, input logic er,
                        input srm_op_t op = OP_CONNECT);
    if (c !== cur_cfg) begin
      axi_wr(`SRM_CFG_ADDR, {25'h0, c}, 4'hF, `SRM_RESP_OKAY);
      cur_cfg = c;
    end
    axi_wr(`SRM_CMD_ADDR, {22'h0, op, d, s}, 4'hF, `SRM_RESP_OKAY);
    axi_rd(`SRM_STAT_ADDR, {31'h0, er}, 32'h1, `SRM_RESP_OKAY);
  endtask

  // Pulse on line 0 from the far board; a note if a trigger is due
  task automatic pulse_line(input int n, input logic due);
    if (due) st_q.push_back(1'b1);
    drive_val[0] <= 1'b1;
    repeat (n) @(posedge mclk);
    drive_val[0] <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask

  task automatic kick();
    @(posedge mclk);
    comm_start <= 1'b1;
    @(posedge mclk);
    comm_start <= 1'b0;
  endtask

  // Watcher: every answer or pulse takes the oldest note
  always @(posedge mclk) begin
    if (rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      rn = rq.pop_front();
      chk("rdata", rn[31:0] & rn[63:32], rdata & rn[63:32]);
      chk("rresp", 32'(rn[65:64]), 32'(rresp));
    end
    if (bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0) begin
      chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    end
    if (start_trigger === 1'b1) begin
      chk("start_trigger", 32'h1, 32'(st_q.size() > 0));
      if (st_q.size() > 0) st_q.delete(0);
    end
    if (resync_pulse === 1'b1) begin
      chk("resync_pulse", 32'h1, 32'(rs_q.size() > 0));
      if (rs_q.size() > 0) rs_q.delete(0);
    end
    if (mtb_tick === 1'b1) begin
      chk("mtb_tick", 32'h1, 32'(mt_q.size() > 0));
      if (mt_q.size() > 0) mt_q.delete(0);
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(32'hAA61));
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    axi_rd(`SRM_CFG_ADDR, 32'h0, 32'h7F, `SRM_RESP_OKAY);
    axi_rd(`SRM_ROUTE_ADDR, 32'h0, 32'hFFFF, `SRM_RESP_OKAY);
    axi_rd(8'h10, 32'h0, 32'hFFFFFFFF, `SRM_RESP_SLVERR);
    axi_wr(8'h10, 32'h0, 4'hF, `SRM_RESP_SLVERR);
    axi_wr(`SRM_CMD_ADDR, 32'hB, 4'h1, `SRM_RESP_SLVERR);
    chk("line_oe_n", 32'hFF, 32'(line_oe_n));
    drive_en <= 8'hFF;
    for (int i = 0; i < 5; i++) begin
      axi_wr(`SRM_CFG_ADDR, 32'(i) << 2, 4'hF, `SRM_RESP_OKAY);
      axi_rd(`SRM_STAT_ADDR, 32'(i) << 24, 32'h07000000, 2'h0);
    end
    cur_cfg = 7'h10;
    do_cmd(7'h00, T_RESYNC, T_LINE0, 1'b0);
    do_cmd(7'h00, T_RESYNC, T_LINE1, 1'b0);
    do_cmd(7'h00, T_RESYNC, T_LINE2, 1'b0);
    do_cmd(7'h00, T_START, T_LINE3, 1'b0);
    do_cmd(7'h00, T_START, T_LINE5, 1'b1);
    do_cmd(7'h00, T_LINE0, T_RESYNC, 1'b1);
    do_cmd(7'h00, T_RX_EVENT, T_LINE4, 1'b1);
    do_cmd(7'h00, T_RESYNC, T_LINE1, 1'b0, OP_DISCONNECT);
    do_cmd(7'h00, T_RESYNC, T_LINE1, 1'b1, OP_DISCONNECT);
    axi_rd(`SRM_ROUTE_ADDR, 32'hD, 32'hFFFF, 2'h0);
    axi_rd(`SRM_STAT_ADDR, 32'h000D0000, 32'hFFFF00, 2'h0);
    chk("line_oe_n", 32'hF2, 32'(line_oe_n));
    do_cmd(7'h00, T_LINE4, T_RESYNC, 1'b0);
    do_cmd(7'h00, T_RESYNC, T_START, 1'b0);
    do_cmd(7'h00, T_LINE0, T_LINE0, 1'b0, OP_CLOSE_LAST);
    axi_rd(`SRM_ROUTE_ADDR, 32'h0, 32'hFFFF, 2'h0);
    do_cmd(7'h40, T_RESYNC, T_LINE0, 1'b0);
    do_cmd(7'h40, T_RESYNC, T_LINE1, 1'b0);
    do_cmd(7'h40, T_RESYNC, T_LINE2, 1'b0);
    do_cmd(7'h40, T_START, T_LINE3, 1'b1);
    do_cmd(7'h40, T_LINE4, T_RESYNC, 1'b0);
    do_cmd(7'h40, T_LINE5, T_START, 1'b0);
    do_cmd(7'h04, T_LINE6, T_RESYNC, 1'b1);
    do_cmd(7'h04, T_RESYNC, T_LINE6, 1'b1);
    do_cmd(7'h04, T_LINE5, T_RESYNC, 1'b0);
    do_cmd(7'h01, T_XCVR_EVENT, T_LINE1, 1'b1);
    do_cmd(7'h01, T_XCVR_EVENT, T_LINE2, 1'b0);
    do_cmd(7'h01, T_STAR, T_START, 1'b1);
    do_cmd(7'h01, T_CLK10, T_MTB, 1'b1);
    do_cmd(7'h01, T_TB_EXPORT, T_CLOCK_LINE, 1'b0);
    do_cmd(7'h01, T_RX_EVENT, T_LINE3, 1'b0);
    chk("line_oe_n", 32'h73, 32'(line_oe_n));
    do_cmd(7'h01, T_LINE0, T_LINE0, 1'b1, OP_NONE);
    do_cmd(7'h21, T_XCVR_EVENT, T_LINE1, 1'b0);
    do_cmd(7'h21, T_XCVR_EVENT, T_LINE2, 1'b1);
    do_cmd(7'h09, T_TB_EXPORT, T_CLOCK_LINE, 1'b1);
    do_cmd(7'h09, T_STAR, T_START, 1'b1);
    do_cmd(7'h09, T_CLK10, T_MTB, 1'b1);
    do_cmd(7'h09, T_LINE4, T_RESYNC, 1'b1);
    do_cmd(7'h09, T_RESYNC, T_LINE5, 1'b1);
    do_cmd(7'h09, T_LINE3, T_RESYNC, 1'b0);
    do_cmd(7'h05, T_STAR, T_START, 1'b0);
    do_cmd(7'h05, T_CLK10, T_MTB, 1'b0);
    chk("mtb_source", 32'h2, 32'(mtb_source));
    repeat (2) begin
      mt_q.push_back(1'b1);
      bp_clk10 <= 1'b1;
      repeat (4) @(posedge mclk);
      bp_clk10 <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    do_cmd(7'h03, T_LINE1, T_START, 1'b1);
    do_cmd(7'h03, T_LINE0, T_START, 1'b0);
    do_cmd(7'h03, T_TB_EXPORT, T_CLOCK_LINE, 1'b0);
    do_cmd(7'h03, T_CLOCK_LINE, T_MTB, 1'b1);
    do_cmd(7'h03, T_RESYNC, T_LINE0, 1'b1);
    chk("export_1mhz", 32'h1, 32'(export_1mhz));
    chk("line_out", 32'(ev_d[0]), 32'(line_out[7]));
    do_cmd(7'h00, T_LINE0, T_START, 1'b0);
    kick();
    pulse_line(1 + $urandom % 4, 1'b0);
    pulse_line(20, 1'b1);
    pulse_line(20, 1'b0);
    do_cmd(7'h00, T_LINE0, T_LINE0, 1'b0, OP_CLOSE_LAST);
    st_q.push_back(1'b1);
    kick();
    repeat (5) @(posedge mclk);
    chk("start notes left", 32'h0, 32'(st_q.size()));
    clk_mask <= 8'h82;
    do_cmd(7'h01, T_LINE1, T_RESYNC, 1'b0);
    do_cmd(7'h01, T_CLOCK_LINE, T_MTB, 1'b0);
    chk("mtb_source", 32'h1, 32'(mtb_source));
    repeat (6) begin
      rs_q.push_back(1'b1);
      mt_q.push_back(1'b1);
    end
    clk_run <= 1'b1;
    repeat (48) @(posedge mclk);
    clk_run <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("resync notes left", 32'h0, 32'(rs_q.size()));
    chk("mtb notes left", 32'h0, 32'(mt_q.size()));
    test_done();
  end
endmodule
